// *** rtl/sdcc_top.sv ***
`timescale 1ns/1ns
// How it works
// - Precharge-all drives CS, RAS, WE low, CAS high, address-ten line high.
// - Activate drives CS, RAS low, CAS, WE high, row on address pins.
// - Read drives CS, CAS low, RAS, WE high, line low, column.
// - Write drives CS, CAS, WE low, RAS high, line low, column.
// - Mode load drives all four strobes low, mode value on pins.
// - Internal address is shifted so row and column share the pins.
// - Address-ten line low on read/write, high on precharge, row bit on activate.
// - Single 16-bit chip: row A[14:12], line, A[10:1]; column A[8:1]/A[9:1].
// - 64-Mbit 32-bit chips: row A[14:13], line, A[11:2]; column A[9:2].
// - Two 16-bit or one 128-Mbit 32-bit: row A[15:13], line, A[11:2].
// - Memory clock runs at full or half output clock rate.
// - In hold, all address, data, select, strobe and clock pins float.
// - Four active-low chip selects and four active-low byte lane masks.
// - Each space keeps its own page row, open only for the last activated space, and compares later accesses.
// - A page miss with a row open issues precharge-all then a new activate first; with none open, only the activate.
// - An ending access leaves its row open.
// - Only one row is open across the whole memory.
// - Any write to the init register starts initialisation.
// - Init sends three no-ops, one precharge, eight refreshes, one mode load.
// - Init register clears itself after the mode load.
// - Mode value 0x030 goes out on A13, line, A11 down to A2.
// - Every command goes to all spaces configured as SDRAM.
// - Read data is captured three memory clocks after the column.
// - Write data is driven with the write command, no latency.
`include "sdcc_consts.svh"

module sdcc_top
    import sdcc_pkg::*;
#(
    parameter int AW = 22,
    parameter int DW = 32
)(
    input  wire logic          CLK_I,
    input  wire logic          SYS_RST_I,
    input  wire logic [3:0]    MEMORY_TYPE_FIELD_I,
    input  wire logic          BUS_ACCESS_WIDTH_SEL_I,
    input  wire logic          CHIP_DENSITY_SEL_I,
    input  wire logic          CHIP_DATA_WIDTH_SEL_I,
    input  wire logic          MEM_CLK_EN_I,
    input  wire logic          MEM_CLK_HALF_I,
    input  wire logic          INIT_WRITE_I,
    output logic               INIT_PENDING_O,
    input  wire logic          HOLD_I,
    input  wire logic          REQ_VALID_I,
    output logic               REQ_READY_O,
    input  wire logic          REQ_WRITE_I,
    input  wire logic [1:0]    REQ_SPACE_I,
    input  wire logic [AW-1:0] REQ_ADDR_I,
    input  wire logic [DW-1:0] REQ_WDATA_I,
    input  wire logic [3:0]    REQ_BE_N_I,
    output logic               RD_VALID_O,
    output logic [DW-1:0]      RD_DATA_O,
    output logic [AW-1:0]      ADDR_O,
    output logic               ADDR_TEN_PRECHARGE_LINE_O,
    output logic [3:0]         CHIP_SELECT_N_O,
    output logic [3:0]         BYTE_LANE_MASK_N_O,
    output logic               ROW_STROBE_N_O,
    output logic               COLUMN_STROBE_N_O,
    output logic               WRITE_STROBE_N_O,
    output logic               MEMORY_CLOCK_OUT_O,
    output logic               PINS_OE_O,
    output logic [DW-1:0]      DATA_O,
    output logic               DATA_OE_O,
    input  wire logic [DW-1:0] DATA_I
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic          hold_m_ff;
    logic          hold_ff;
    logic [DW-1:0] din_m_ff;
    logic [DW-1:0] din_ff;

    // Second stage alone feeds logic
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            hold_m_ff <= 1'b0;
            hold_ff   <= 1'b0;
            din_m_ff  <= '0;
            din_ff    <= '0;
        end
        else
        begin
            hold_m_ff <= HOLD_I;
            hold_ff   <= hold_m_ff;
            din_m_ff  <= DATA_I;
            din_ff    <= din_m_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory clock divider; commands move on its falling edge
    logic mclk_ff;
    logic div_ff;
    logic toggle;
    logic tick;

    assign toggle = MEM_CLK_EN_I && (!MEM_CLK_HALF_I || div_ff);
    // Stalls while held so nothing moves with the pins floating
    assign tick   = toggle && mclk_ff && !hold_ff;

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            mclk_ff <= 1'b1;
            div_ff  <= 1'b0;
        end
        else if (!MEM_CLK_EN_I)
        begin
            mclk_ff <= 1'b1;    // Parked high when disabled
            div_ff  <= 1'b0;
        end
        else
        begin
            div_ff <= MEM_CLK_HALF_I ? !div_ff : 1'b0;
            if (toggle && !(mclk_ff && hold_ff))
                mclk_ff <= !mclk_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address split per organisation
    logic          narrow_map;
    logic [3:0]    col_w;
    logic [3:0]    row_w;
    logic [1:0]    shf;
    logic [AW-1:0] col_f;
    logic [AW-1:0] row_f;
    logic [AW-1:0] req_col;
    logic [AW-1:0] req_row;

    // 16-bit access uses half-word steps, 32-bit uses words
    assign narrow_map = !BUS_ACCESS_WIDTH_SEL_I;
    assign shf   = narrow_map ? 2'h1 : 2'h2;
    assign col_w = (narrow_map && CHIP_DENSITY_SEL_I) ?
                   `SDCC_COL_WIDE : `SDCC_COL_NARROW;
    // 64-Mbit 32-bit parts have one row bit fewer
    assign row_w = (!narrow_map && !CHIP_DENSITY_SEL_I &&
                    CHIP_DATA_WIDTH_SEL_I) ?
                   `SDCC_ROW_NARROW : `SDCC_ROW_WIDE;
    assign col_f = (REQ_ADDR_I >> shf) & ~({AW{1'b1}} << col_w);
    // Shift amount kept wide enough for column width plus lane step
    assign row_f = (REQ_ADDR_I >> (5'(shf) + 5'(col_w))) &
                   ~({AW{1'b1}} << row_w);
    assign req_col = col_f;
    assign req_row = row_f;

    ////////////////////////////////////////////////////////////////////////
    // Open page per space
    logic [3:0]    page_vld_ff;
    logic [AW-1:0] page_row_ff [4];
    logic          page_hit;

    assign page_hit = page_vld_ff[REQ_SPACE_I] &&
                      (page_row_ff[REQ_SPACE_I] == req_row);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    sdcc_state_t   state_ff;
    sdcc_state_t   nxt_state;
    logic [3:0]    cnt_ff;
    logic          init_ff;
    logic          wr_ff;
    logic [1:0]    space_ff;
    logic [AW-1:0] row_ff;
    logic [AW-1:0] col_ff;
    logic [DW-1:0] wdata_ff;
    logic [3:0]    be_n_ff;
    logic          rd_done;
    logic          take;

    assign take = tick && (state_ff == SDCC_S_IDLE) && !init_ff &&
                  REQ_VALID_I;
    assign REQ_READY_O = tick && (state_ff == SDCC_S_IDLE) && !init_ff;

    // Next state, taken on a tick, or on rd_done while in the read wait
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            SDCC_S_IDLE:
                if (init_ff)
                    nxt_state = SDCC_S_INIT_NOP;
                else if (REQ_VALID_I && page_hit)
                    nxt_state = SDCC_S_COL;
                else if (REQ_VALID_I && |page_vld_ff)
                    nxt_state = SDCC_S_PRE;
                else if (REQ_VALID_I)
                    nxt_state = SDCC_S_ACT;
            SDCC_S_INIT_NOP:
                if (cnt_ff == `SDCC_INIT_NOPS - 4'h1)
                    nxt_state = SDCC_S_INIT_PRE;
            SDCC_S_INIT_PRE:
                nxt_state = SDCC_S_INIT_REF;
            SDCC_S_INIT_REF:
                if (cnt_ff == `SDCC_INIT_REFS - 4'h1)
                    nxt_state = SDCC_S_INIT_MRS;
            SDCC_S_INIT_MRS:
                nxt_state = SDCC_S_IDLE;
            SDCC_S_PRE:
                nxt_state = SDCC_S_ACT;
            SDCC_S_ACT:
                nxt_state = SDCC_S_COL;
            SDCC_S_COL:
                nxt_state = wr_ff ? SDCC_S_IDLE : SDCC_S_RD_WAIT;
            SDCC_S_RD_WAIT:
                if (rd_done)
                    nxt_state = SDCC_S_IDLE;
            default:
                nxt_state = SDCC_S_IDLE;
        endcase
    end

    // State and repeat counter
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            state_ff <= SDCC_S_IDLE;
            cnt_ff   <= 4'h0;
        end
        else if (tick || (state_ff == SDCC_S_RD_WAIT && rd_done))
        begin
            state_ff <= nxt_state;
            cnt_ff   <= (nxt_state == state_ff) ? cnt_ff + 4'h1 : 4'h0;
        end
    end

    // Init request flag; a new write wins over the self clear
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            init_ff <= 1'b0;
        else if (INIT_WRITE_I)
            init_ff <= 1'b1;
        else if (tick && state_ff == SDCC_S_INIT_MRS)
            init_ff <= 1'b0;
    end
    assign INIT_PENDING_O = init_ff;

    // Accepted request
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            wr_ff    <= 1'b0;
            space_ff <= 2'h0;
            row_ff   <= '0;
            col_ff   <= '0;
            wdata_ff <= '0;
            be_n_ff  <= 4'hF;
        end
        else if (take)
        begin
            wr_ff    <= REQ_WRITE_I;
            space_ff <= REQ_SPACE_I;
            row_ff   <= req_row;
            col_ff   <= req_col;
            wdata_ff <= REQ_WDATA_I;
            be_n_ff  <= REQ_BE_N_I;
        end
    end

    // Page table; precharge forgets all, activate keeps only one
    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            page_vld_ff <= 4'h0;
        else if (tick && (state_ff == SDCC_S_PRE ||
                          state_ff == SDCC_S_INIT_PRE))
            page_vld_ff <= 4'h0;
        else if (tick && state_ff == SDCC_S_ACT)
            page_vld_ff <= 4'h1 << space_ff;
    end

    for (genvar g = 0; g < 4; g++)
    begin : g_page
        always_ff @(posedge CLK_I or posedge SYS_RST_I)
        begin
            if (SYS_RST_I)
                page_row_ff[g] <= '0;
            else if (tick && state_ff == SDCC_S_ACT && space_ff == g)
                page_row_ff[g] <= row_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers, changed only on a tick
    logic [2:0]    cmd_ff;
    logic [AW-1:0] addr_ff;
    logic          a10_ff;
    logic [3:0]    cs_n_ff;
    logic [3:0]    be_o_ff;
    logic [DW-1:0] dout_ff;
    logic          doe_ff;
    logic [AW-1:0] row_pins;
    logic [AW-1:0] col_pins;
    logic [AW-1:0] mrs_pins;
    logic [11:0]   mode_val;

    // Row: low ten bits on A[9+s:s], bit ten on the line, top above it
    assign row_pins = ((row_ff & AW'(10'h3FF)) << shf) |
                      ((row_ff >> `SDCC_HIGH_LSB) <<
                       (narrow_map ? 4'hC : 4'hD));
    assign col_pins = col_ff << shf;
    assign mode_val = `SDCC_MODE_VALUE;
    assign mrs_pins = (AW'(`SDCC_MODE_VALUE & 12'h3FF) << 2) |
                      (AW'(`SDCC_MODE_VALUE >> 11) << 13);

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            cmd_ff  <= `SDCC_CMD_NOP;
            addr_ff <= '0;
            a10_ff  <= 1'b0;
            cs_n_ff <= 4'hF;
            be_o_ff <= 4'hF;
            dout_ff <= '0;
            doe_ff  <= 1'b0;
        end
        else if (tick)
        begin
            cs_n_ff <= ~MEMORY_TYPE_FIELD_I;
            be_o_ff <= 4'hF;
            doe_ff  <= 1'b0;
            cmd_ff  <= `SDCC_CMD_NOP;
            unique case (state_ff)
                SDCC_S_INIT_PRE, SDCC_S_PRE:
                begin
                    cmd_ff <= `SDCC_CMD_PRE;
                    a10_ff <= 1'b1;
                end
                SDCC_S_INIT_REF:
                    cmd_ff <= `SDCC_CMD_REF;
                SDCC_S_INIT_MRS:
                begin
                    cmd_ff  <= `SDCC_CMD_MRS;
                    addr_ff <= mrs_pins;
                    a10_ff  <= mode_val[10];
                end
                SDCC_S_ACT:
                begin
                    cmd_ff  <= `SDCC_CMD_ACT;
                    addr_ff <= row_pins;
                    a10_ff  <= row_ff[`SDCC_LINE_BIT];
                end
                SDCC_S_COL:
                begin
                    cmd_ff  <= wr_ff ? `SDCC_CMD_WR : `SDCC_CMD_RD;
                    addr_ff <= col_pins;
                    a10_ff  <= 1'b0;
                    be_o_ff <= be_n_ff;
                    dout_ff <= wdata_ff;
                    doe_ff  <= wr_ff;
                end
                default:
                    cmd_ff <= `SDCC_CMD_NOP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read capture: latency in memory clocks, then the synchroniser delay
    logic       rd_act_ff;
    logic [2:0] lat_ff;
    logic [1:0] sdly_ff;
    logic       rdv_ff;
    logic [DW-1:0] rdat_ff;

    assign rd_done = rdv_ff;

    always_ff @(posedge CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            rd_act_ff <= 1'b0;
            lat_ff    <= 3'h0;
            sdly_ff   <= 2'h0;
            rdv_ff    <= 1'b0;
            rdat_ff   <= '0;
        end
        else
        begin
            rdv_ff <= 1'b0;
            if (tick && state_ff == SDCC_S_COL && !wr_ff)
            begin
                rd_act_ff <= 1'b1;
                lat_ff    <= 3'h0;
                sdly_ff   <= 2'h0;
            end
            else if (rd_act_ff && lat_ff != `SDCC_RD_LAT)
            begin
                if (tick)
                    lat_ff <= lat_ff + 3'h1;
            end
            else if (rd_act_ff && sdly_ff != `SDCC_SYNC_DLY)
                sdly_ff <= sdly_ff + 2'h1;
            else if (rd_act_ff)
            begin
                rd_act_ff <= 1'b0;
                rdv_ff    <= 1'b1;
                rdat_ff   <= din_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; hold floats everything through the enables
    assign {ROW_STROBE_N_O, COLUMN_STROBE_N_O, WRITE_STROBE_N_O} = cmd_ff;
    assign ADDR_O                    = addr_ff;
    assign ADDR_TEN_PRECHARGE_LINE_O = a10_ff;
    assign CHIP_SELECT_N_O           = cs_n_ff;
    assign BYTE_LANE_MASK_N_O        = be_o_ff;
    assign MEMORY_CLOCK_OUT_O        = mclk_ff;
    assign DATA_O                    = dout_ff;
    assign PINS_OE_O                 = !hold_ff;
    assign DATA_OE_O                 = doe_ff && !hold_ff;
    assign RD_VALID_O                = rdv_ff;
    assign RD_DATA_O                 = rdat_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);

    property p_pre_line;
        cmd_ff == `SDCC_CMD_PRE |-> a10_ff && cs_n_ff == ~MEMORY_TYPE_FIELD_I
            || $changed(MEMORY_TYPE_FIELD_I) || !$past(tick);
    endproperty
    a_pre_line: assert property (p_pre_line)
        else $error("precharge without line high");

    property p_col_line;
        (cmd_ff == `SDCC_CMD_RD || cmd_ff == `SDCC_CMD_WR) |-> !a10_ff;
    endproperty
    a_col_line: assert property (p_col_line)
        else $error("line high on column command");

    property p_wr_data;
        tick && state_ff == SDCC_S_COL && wr_ff
            |=> cmd_ff == `SDCC_CMD_WR && doe_ff && dout_ff == $past(wdata_ff);
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("write data not with write command");

    property p_pre_then_act;
        tick && state_ff == SDCC_S_PRE |=> state_ff == SDCC_S_ACT;
    endproperty
    a_pre_then_act: assert property (p_pre_then_act)
        else $error("precharge not followed by activate");

    property p_one_row;
        $onehot0(page_vld_ff);
    endproperty
    a_one_row: assert property (p_one_row)
        else $error("more than one open row");

    property p_init_start;
        tick && state_ff == SDCC_S_IDLE && init_ff
            |=> state_ff == SDCC_S_INIT_NOP;
    endproperty
    a_init_start: assert property (p_init_start)
        else $error("init not started");

    property p_init_clear;
        tick && state_ff == SDCC_S_INIT_MRS && !INIT_WRITE_I
            |=> !init_ff && cmd_ff == `SDCC_CMD_MRS;
    endproperty
    a_init_clear: assert property (p_init_clear)
        else $error("init flag not cleared after mode load");

    property p_mrs_pins;
        cmd_ff == `SDCC_CMD_MRS |-> addr_ff == AW'(22'h000C0) && !a10_ff;
    endproperty
    a_mrs_pins: assert property (p_mrs_pins)
        else $error("wrong mode value on pins");

    // Held pins float and the command pins stop moving
    property p_hold_float;
        hold_ff |-> !PINS_OE_O && !DATA_OE_O && !REQ_READY_O &&
            (!$past(hold_ff) || $stable(cmd_ff));
    endproperty
    a_hold_float: assert property (p_hold_float)
        else $error("pins driven during hold");

    property p_keep_open;
        tick && state_ff == SDCC_S_COL |=> page_vld_ff == $past(page_vld_ff);
    endproperty
    a_keep_open: assert property (p_keep_open)
        else $error("row closed at end of access");

endmodule // sdcc_top

// *** common/sdcc_consts.svh ***
`ifndef SDCC_CONSTS_SVH
`define SDCC_CONSTS_SVH

// Command codes on {row, column, write} strobes, all active low
`define SDCC_CMD_PRE     3'h2
`define SDCC_CMD_ACT     3'h3
`define SDCC_CMD_RD      3'h5
`define SDCC_CMD_WR      3'h4
`define SDCC_CMD_MRS     3'h0
`define SDCC_CMD_REF     3'h1
`define SDCC_CMD_NOP     3'h7

// Fixed mode value: burst 1, sequential, latency 3, write burst 1
`define SDCC_MODE_VALUE  12'h030

// Power-up sequence counts
`define SDCC_INIT_NOPS   4'h3
`define SDCC_INIT_REFS   4'h8

// Read latency in memory clocks and pin synchroniser depth
`define SDCC_RD_LAT      3'h3
`define SDCC_SYNC_DLY    2'h2

// Address field layout
`define SDCC_COL_NARROW  4'h8
`define SDCC_COL_WIDE    4'h9
`define SDCC_ROW_WIDE    4'hE
`define SDCC_ROW_NARROW  4'hD
`define SDCC_LINE_BIT    4'hA
`define SDCC_HIGH_LSB    4'hB

`endif

// *** common/sdcc_pkg.sv ***
package sdcc_pkg;

    // Sequencer states, one-hot
    typedef enum logic [8:0] {
        SDCC_S_IDLE     = 9'h001,
        SDCC_S_INIT_NOP = 9'h002,
        SDCC_S_INIT_PRE = 9'h004,
        SDCC_S_INIT_REF = 9'h008,
        SDCC_S_INIT_MRS = 9'h010,
        SDCC_S_PRE      = 9'h020,
        SDCC_S_ACT      = 9'h040,
        SDCC_S_COL      = 9'h080,
        SDCC_S_RD_WAIT  = 9'h100
    } sdcc_state_t;

endpackage

// *** verif/sdcc_sdram_model.sv ***
`timescale 1ns/1ns
module sdcc_sdram_model (
    input  wire logic        mclk_i,
    input  wire logic [3:0]  cs_n_i,
    input  wire logic [3:0]  be_n_i,
    input  wire logic [2:0]  cmd_i,
    input  wire logic        line_i,
    input  wire logic [21:0] addr_i,
    input  wire logic [31:0] dq_i,
    input  wire logic        dq_oe_i,
    output logic [31:0]      dq_o
);
    logic [31:0] mem [logic [44:0]];
    logic [22:0] row_ff;
    logic [31:0] pipe [3];
    logic [2:0]  vld;
    logic [31:0] last;
    logic [11:0] seq;
    int          cnt;
    logic [3:0]  cs_seen;
    logic [3:0]  be_seen;
    logic        line_seen;
    logic [21:0] addr_seen;
    initial
    begin
        vld = 3'h0;
        last = 32'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Released pins show the inverse of the last word, never a stale copy
    assign dq_o = vld[2] ? pipe[2] : ~last;
    // Commands sampled on the rising memory clock, data three clocks later
    always @(posedge mclk_i)
    begin
        if (vld[2]) last <= pipe[2];
        vld <= {vld[1:0], 1'b0};
        pipe[1] <= pipe[0];
        pipe[2] <= pipe[1];
        if (cs_n_i != 4'hF && cmd_i != 3'h7)
        begin
            seq <= {seq[8:0], cmd_i};
            cnt <= cnt + 1;
            cs_seen <= cs_n_i;
            line_seen <= line_i;
            addr_seen <= addr_i;
            if (cmd_i == 3'h4 || cmd_i == 3'h5) be_seen <= be_n_i;
            // Closed row forgets its page, so a missing activate shows up
            if (cmd_i == 3'h2) row_ff <= 'x;
            if (cmd_i == 3'h3) row_ff <= {line_i, addr_i};
            // Undriven write data stores unknown
            if (cmd_i == 3'h4) mem[{row_ff, addr_i}] = dq_oe_i ? dq_i : 'x;
            if (cmd_i == 3'h5)
            begin
                vld[0] <= 1'b1;
                pipe[0] <= mem.exists({row_ff, addr_i}) ?
                           mem[{row_ff, addr_i}] : 32'h0;
            end
        end
    end
endmodule // sdcc_sdram_model

// *** verif/sdram_command_controller_tb.sv ***
`timescale 1ns/1ns
module sdram_command_controller_tb;
    logic        clk, rst, half, init, hold, valid, wr, pend, ready, rvalid;
    logic        line, ras, cas, we, mclk, pins_oe, dq_oe;
    logic [2:0]  cfg;
    logic [1:0]  sp;
    logic [3:0]  memory_type_field, cs_n, be_n, mask;
    logic [21:0] addr, a_o;
    logic [31:0] wdata, rdata, dq_in, dq_out, d;
    logic [2:0]  tbl [5] = '{3'h0, 3'h2, 3'h5, 3'h4, 3'h7};
    int          num_errors, n_tests, cyc, nrv;
    time         t0;
    sdcc_top DUT (.CLK_I(clk), .SYS_RST_I(rst), .MEMORY_TYPE_FIELD_I(memory_type_field),
        .BUS_ACCESS_WIDTH_SEL_I(cfg[2]), .CHIP_DENSITY_SEL_I(cfg[1]),
        .CHIP_DATA_WIDTH_SEL_I(cfg[0]), .MEM_CLK_EN_I(1'b1),
        .MEM_CLK_HALF_I(half), .INIT_WRITE_I(init), .INIT_PENDING_O(pend),
        .HOLD_I(hold), .REQ_VALID_I(valid), .REQ_READY_O(ready),
        .REQ_WRITE_I(wr), .REQ_SPACE_I(sp), .REQ_ADDR_I(addr),
        .REQ_WDATA_I(wdata), .REQ_BE_N_I(mask), .RD_VALID_O(rvalid),
        .RD_DATA_O(rdata), .ADDR_O(a_o), .ADDR_TEN_PRECHARGE_LINE_O(line),
        .CHIP_SELECT_N_O(cs_n), .BYTE_LANE_MASK_N_O(be_n),
        .ROW_STROBE_N_O(ras), .COLUMN_STROBE_N_O(cas), .WRITE_STROBE_N_O(we),
        .MEMORY_CLOCK_OUT_O(mclk), .PINS_OE_O(pins_oe), .DATA_O(dq_out),
        .DATA_OE_O(dq_oe), .DATA_I(dq_in));
    sdcc_sdram_model m (.mclk_i(mclk), .cs_n_i(cs_n), .be_n_i(be_n),
        .cmd_i({ras, cas, we}),
        .line_i(line), .addr_i(a_o), .dq_i(dq_out), .dq_oe_i(dq_oe),
        .dq_o(dq_in));
    ////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the ceiling is far above the expected run
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            tally_and_finish;
        end
    end
    // Read valid pulses, counted where the register has settled
    always @(negedge clk)
        if (rvalid === 1'b1) nrv++;
    task check(input string what, input logic [35:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Ready only rises on a tick, so poll it where it is settled
    task wait_ready;
        for (int i = 0; i < 300 && ready !== 1'b1; i++) @(negedge clk);
        if (ready !== 1'b1) num_errors++;
    endtask
    task op(input logic w, input logic [21:0] a, input logic [31:0] dv,
            input logic [8:0] exp, input logic chk);
        int n0;
        @(negedge clk);
        {valid, wr, addr, wdata, mask} = {1'b1, w, a, dv, dv[3:0]};
        m.seq = 12'h0;
        n0 = nrv;
        wait_ready;
        @(negedge clk);
        valid = 1'b0;
        wait_ready;
        if (chk) check("command order", m.seq[8:0], exp);
        check("selects", m.cs_seen, 4'(~memory_type_field));
        check("lane masks", m.be_seen, dv[3:0]);
        check("read pulses", nrv - n0, !w);
        if (!w) check("read data", rdata, dv);
        if (!w) check("line on read", m.line_seen, 1'b0);
    endtask
    task do_init;
        @(negedge clk);
        {init, m.seq, m.cnt} = {1'b1, 12'h0, 32'h0};
        @(negedge clk);
        init = 1'b0;
        check("init pending", pend, 1'b1);
        for (int i = 0; i < 300 && pend !== 1'b0; i++) @(negedge clk);
        // Mode load reaches the memory on the next clock rise
        repeat (2) @(negedge clk);
        check("init done", pend, 1'b0);
        check("init count", m.cnt, 10);
        check("init tail", m.seq, 12'h248);
        check("mode value", {m.line_seen, m.addr_seen}, 23'h0000C0);
        check("init selects", m.cs_seen, 4'(~memory_type_field));
    endtask
    task measure(input int exp);
        repeat (3) @(posedge mclk);
        t0 = $time;
        @(posedge mclk);
        check("memory clock period", ($time - t0) / 10, exp);
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence: one pass per configuration in tbl, both pages reused
    initial
    begin
        {rst, half, init, hold, valid, wr, cfg} = {1'b1, 8'h0};
        {addr, wdata, memory_type_field, mask, sp} = {54'h0, 4'h5, 6'h3C};
        repeat (10) @(negedge clk);
        check("reset strobes", {cs_n, ras, cas, we}, 7'h7F);
        check("reset pending", pend, 1'b0);
        rst = 1'b0;
        measure(2);
        for (int k = 0; k < 5; k++)
        begin
            cfg = tbl[k];
            d = 32'hA5C30000 + k;
            do_init;
            op(1'b1, 22'h000010, d, 9'h0, 1'b0);
            op(1'b1, 22'h010010, ~d, 9'h09C, 1'b1);
            op(1'b0, 22'h000010, d, 9'h09D, 1'b1);
            op(1'b0, 22'h000010, d, 9'h005, 1'b1);
            op(1'b0, 22'h010010, ~d, 9'h09D, 1'b1);
            // Same row in another space misses, then closes space 0
            sp = 2'h2;
            op(1'b0, 22'h010010, ~d, 9'h09D, 1'b1);
            sp = 2'h0;
            op(1'b0, 22'h010010, ~d, 9'h09D, 1'b1);
        end
        half = 1'b1;
        measure(4);
        @(negedge clk);
        hold = 1'b1;
        repeat (6) @(negedge clk);
        check("pins in hold", {pins_oe, ready}, 2'h0);
        hold = 1'b0;
        repeat (4) @(negedge clk);
        check("pins after hold", pins_oe, 1'b1);
        tally_and_finish;
    end
endmodule // sdram_command_controller_tb
